//--- verilog/spg_defs.vh
// Constants for the shared pin GPIO ports.
`ifndef SPG_DEFS_VH
`define SPG_DEFS_VH
`define SPG_OFS_P4_DATA 4'h0
`define SPG_OFS_P4_DIR 4'h1
`define SPG_OFS_P5_DATA 4'h2
`define SPG_OFS_P5_DIR 4'h3
`define SPG_OFS_P5_PULL 4'h4
`define SPG_OFS_P6_DATA 4'h5
`define SPG_OFS_P6_DIR 4'h6
`define SPG_OFS_STBY 4'h7
`define SPG_OFS_DISP 4'h8
`define SPG_FLD_HIZ 0
`define SPG_FLD_SEG4_LO 0
`define SPG_FLD_SEG6_LO 8
`define SPG_FLD_PORT_INPUT_CONTROL 16
`define SPG_RST_DIR 8'h00
`define SPG_RST_DATA 8'h00
`define SPG_RST_PULL 8'h00
`define SPG_RST_DIR4 4'h0
`define SPG_RST_DATA4 4'h0
`define SPG_RST_PULL4 4'h0
`define SPG_RST_DISP 17'h0_0000
`endif

//--- verilog/spg_pin_bank.v
// Pin drive and read-back path for one group of port pins.
`timescale 1ns/1ns
`default_nettype none
module spg_pin_bank #(
    parameter W = 4
) (
    input wire [W-1:0] latch_i,
    input wire [W-1:0] dir_i,
    input wire [W-1:0] alt_oe_i,
    input wire [W-1:0] alt_out_i,
    input wire [W-1:0] pin_sync_i,
    input wire in_enable_i,
    input wire hiz_i,
    input wire rmw_i,
    output wire [W-1:0] pin_o,
    output wire [W-1:0] pin_oe_o,
    output wire [W-1:0] in_o,
    output wire [W-1:0] read_o
);
    wire [W-1:0] port_drv;
    wire [W-1:0] lvl;

    // A peripheral with its enable set takes the pin over.
    assign port_drv = dir_i & ~alt_oe_i;
    // Latch bit one gives high, zero gives low.
    assign pin_o = (alt_oe_i & alt_out_i) | (port_drv & latch_i);
    // Input pins without a peripheral enable, and hi-Z standby, release the pin.
    assign pin_oe_o = hiz_i ? {W{1'b0}} : (dir_i | alt_oe_i);
    // The input is held low in hi-Z standby to stop leakage.
    assign lvl = (hiz_i || !in_enable_i) ? {W{1'b0}} : pin_sync_i;
    assign in_o = lvl;
    // Latch for READ_MODIFY_WRITE and pure port outputs, level otherwise.
    assign read_o = rmw_i ? latch_i
                  : ((port_drv & latch_i) | (~port_drv & lvl));
endmodule
`default_nettype wire

//--- verilog/spg_gpio.v
// Shared pin GPIO ports 4, 5 and 6 with an Avalon-MM register slave.
`timescale 1ns/1ns
`default_nettype none
`include "spg_defs.vh"
module spg_gpio (
    input wire clk_sys_i,
    input wire nrst_i,
    input wire [5:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    output reg [31:0] avs_readdata_o,
    output wire avs_waitrequest_o,
    input wire read_modify_write_i,
    input wire standby_stop_i,
    input wire standby_watch_i,
    input wire [3:0] port4_pin_i,
    output wire [3:0] port4_pin_o,
    output wire [3:0] port4_pin_oe_o,
    input wire [3:0] port5_pin_i,
    output wire [3:0] port5_pin_o,
    output wire [3:0] port5_pin_oe_o,
    output wire [3:0] port5_pullup_en_o,
    input wire [7:0] port6_pin_i,
    output wire [7:0] port6_pin_o,
    output wire [7:0] port6_pin_oe_o,
    input wire ctimer0_out_b_i,
    input wire ctimer0_out_b_oe_i,
    input wire ctimer0_out_a_i,
    input wire ctimer0_out_a_oe_i,
    input wire reload_timer_out_i,
    input wire reload_timer_out_oe_i,
    output wire ctimer0_ext_clk_o,
    output wire reload_timer_in_o,
    input wire [3:0] segment4_i,
    input wire [7:0] segment6_i
);
    reg rst_meta;
    reg rst_sync_n;
    reg ack;
    reg [3:0] port4_data;
    reg [3:0] port4_direction;
    reg [3:0] port5_data;
    reg [3:0] port5_direction;
    reg [3:0] port5_pullup;
    reg [7:0] port6_data;
    reg [7:0] port6_direction;
    reg standby_pin_hiz;
    reg [3:0] segment_select4;
    reg [7:0] segment_select6;
    reg port_input_control;
    reg [3:0] p4_meta;
    reg [3:0] p4_sync;
    reg [3:0] p5_meta;
    reg [3:0] p5_sync;
    reg [7:0] p6_meta;
    reg [7:0] p6_sync;
    reg [31:0] next_readdata;
    wire [3:0] widx;
    wire req;
    wire wr_go;
    wire hiz;
    wire read_modify_write;
    wire [3:0] seg4_on;
    wire [7:0] seg6_on;
    wire [3:0] p5_alt_oe;
    wire [3:0] p5_alt_out;
    wire [3:0] p4_rd;
    wire [3:0] p5_rd;
    wire [7:0] p6_rd;
    wire [3:0] p5_in;

    // Merges one byte lane of write data into an old register value.
    function [7:0] lane_merge;
        input [7:0] old_val;
        input [7:0] new_val;
        input lane_en;
        begin
            lane_merge = lane_en ? new_val : old_val;
        end
    endfunction

    // Merges the low nibble of lane zero into a four-bit register.
    function [3:0] nib_merge;
        input [3:0] old_val;
        input [3:0] new_val;
        input lane_en;
        begin
            nib_merge = lane_en ? new_val : old_val;
        end
    endfunction

    always @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    assign widx = avs_address_i[5:2];
    assign req = avs_read_i | avs_write_i;
    // One wait cycle lets read data settle in a flip-flop.
    assign avs_waitrequest_o = req & ~ack;
    assign wr_go = avs_write_i & ack;
    assign hiz = standby_pin_hiz & (standby_stop_i | standby_watch_i);
    assign read_modify_write = read_modify_write_i;

    always @(posedge clk_sys_i or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            ack <= 1'b0;
        end
        else
        begin
            ack <= req & ~ack;
        end
    end

    // Pin levels come from outside and are synchronised first.
    always @(posedge clk_sys_i or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            p4_meta <= 4'h0;
            p4_sync <= 4'h0;
            p5_meta <= 4'h0;
            p5_sync <= 4'h0;
            p6_meta <= 8'h00;
            p6_sync <= 8'h00;
        end
        else
        begin
            p4_meta <= port4_pin_i;
            p4_sync <= p4_meta;
            p5_meta <= port5_pin_i;
            p5_sync <= p5_meta;
            p6_meta <= port6_pin_i;
            p6_sync <= p6_meta;
        end
    end

    always @(posedge clk_sys_i or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            port4_data <= `SPG_RST_DATA4;
            port5_data <= `SPG_RST_DATA4;
            port6_data <= `SPG_RST_DATA;
            port4_direction <= `SPG_RST_DIR4;
            port5_direction <= `SPG_RST_DIR4;
            port6_direction <= `SPG_RST_DIR;
            port5_pullup <= `SPG_RST_PULL4;
            standby_pin_hiz <= 1'b0;
            segment_select4 <= 4'h0;
            segment_select6 <= 8'h00;
            port_input_control <= 1'b0;
        end
        else if (wr_go)
        begin
            case (widx)
                `SPG_OFS_P4_DATA:
                begin
                    // The latch takes data whatever the direction.
                    port4_data <= nib_merge(port4_data,
                        avs_writedata_i[3:0], avs_byteenable_i[0]);
                end
                `SPG_OFS_P4_DIR:
                begin
                    port4_direction <= nib_merge(port4_direction,
                        avs_writedata_i[3:0], avs_byteenable_i[0]);
                end
                `SPG_OFS_P5_DATA:
                begin
                    port5_data <= nib_merge(port5_data,
                        avs_writedata_i[3:0], avs_byteenable_i[0]);
                end
                `SPG_OFS_P5_DIR:
                begin
                    port5_direction <= nib_merge(port5_direction,
                        avs_writedata_i[3:0], avs_byteenable_i[0]);
                end
                `SPG_OFS_P5_PULL:
                begin
                    port5_pullup <= nib_merge(port5_pullup,
                        avs_writedata_i[3:0], avs_byteenable_i[0]);
                end
                `SPG_OFS_P6_DATA:
                begin
                    port6_data <= lane_merge(port6_data,
                        avs_writedata_i[7:0], avs_byteenable_i[0]);
                end
                `SPG_OFS_P6_DIR:
                begin
                    port6_direction <= lane_merge(port6_direction,
                        avs_writedata_i[7:0], avs_byteenable_i[0]);
                end
                `SPG_OFS_STBY:
                begin
                    if (avs_byteenable_i[0])
                    begin
                        standby_pin_hiz <= avs_writedata_i[`SPG_FLD_HIZ];
                    end
                end
                `SPG_OFS_DISP:
                begin
                    segment_select4 <= nib_merge(segment_select4,
                        avs_writedata_i[3:0], avs_byteenable_i[0]);
                    segment_select6 <= lane_merge(segment_select6,
                        avs_writedata_i[15:8], avs_byteenable_i[1]);
                    if (avs_byteenable_i[2])
                    begin
                        port_input_control <=
                            avs_writedata_i[`SPG_FLD_PORT_INPUT_CONTROL];
                    end
                end
                default:
                begin
                    port_input_control <= port_input_control;
                end
            endcase
        end
    end

    // A segment drives its pin only once the input control is set.
    assign seg4_on = segment_select4 & {4{port_input_control}};
    assign seg6_on = segment_select6 & {8{port_input_control}};

    // Bit 1 is only a timer clock input and has no output.
    assign p5_alt_oe = {reload_timer_out_oe_i, ctimer0_out_a_oe_i,
                        1'b0, ctimer0_out_b_oe_i};
    assign p5_alt_out = {reload_timer_out_i, ctimer0_out_a_i,
                         1'b0, ctimer0_out_b_i};

    spg_pin_bank #(
        .W(4)
    ) u_port4 (
        .latch_i(port4_data),
        .dir_i(port4_direction),
        .alt_oe_i(seg4_on),
        .alt_out_i(segment4_i),
        .pin_sync_i(p4_sync),
        .in_enable_i(port_input_control),
        .hiz_i(hiz),
        .rmw_i(read_modify_write),
        .pin_o(port4_pin_o),
        .pin_oe_o(port4_pin_oe_o),
        .in_o(),
        .read_o(p4_rd)
    );

    spg_pin_bank #(
        .W(4)
    ) u_port5 (
        .latch_i(port5_data),
        .dir_i(port5_direction),
        .alt_oe_i(p5_alt_oe),
        .alt_out_i(p5_alt_out),
        .pin_sync_i(p5_sync),
        .in_enable_i(1'b1),
        .hiz_i(hiz),
        .rmw_i(read_modify_write),
        .pin_o(port5_pin_o),
        .pin_oe_o(port5_pin_oe_o),
        .in_o(p5_in),
        .read_o(p5_rd)
    );

    spg_pin_bank #(
        .W(8)
    ) u_port6 (
        .latch_i(port6_data),
        .dir_i(port6_direction),
        .alt_oe_i(seg6_on),
        .alt_out_i(segment6_i),
        .pin_sync_i(p6_sync),
        .in_enable_i(port_input_control),
        .hiz_i(hiz),
        .rmw_i(read_modify_write),
        .pin_o(port6_pin_o),
        .pin_oe_o(port6_pin_oe_o),
        .in_o(),
        .read_o(p6_rd)
    );

    // Timer inputs see the pin level, even while the pin is driven as an output.
    assign ctimer0_ext_clk_o = p5_in[1];
    assign reload_timer_in_o = p5_in[2];

    // The pull-up cannot fight a pin that is driven low.
    assign port5_pullup_en_o = port5_pullup
        & ~(port5_pin_oe_o & ~port5_pin_o);

    always @*
    begin
        next_readdata = 32'h0000_0000;
        case (widx)
            `SPG_OFS_P4_DATA:
            begin
                next_readdata = {28'h000_0000, p4_rd};
            end
            `SPG_OFS_P4_DIR:
            begin
                next_readdata = {28'h000_0000, port4_direction};
            end
            `SPG_OFS_P5_DATA:
            begin
                next_readdata = {28'h000_0000, p5_rd};
            end
            `SPG_OFS_P5_DIR:
            begin
                next_readdata = {28'h000_0000, port5_direction};
            end
            `SPG_OFS_P5_PULL:
            begin
                next_readdata = {28'h000_0000, port5_pullup};
            end
            `SPG_OFS_P6_DATA:
            begin
                next_readdata = {24'h00_0000, p6_rd};
            end
            `SPG_OFS_P6_DIR:
            begin
                next_readdata = {24'h00_0000, port6_direction};
            end
            `SPG_OFS_STBY:
            begin
                next_readdata = {31'h0000_0000, standby_pin_hiz};
            end
            `SPG_OFS_DISP:
            begin
                next_readdata = {15'h0000, port_input_control,
                                 segment_select6, 4'h0, segment_select4};
            end
            default:
            begin
                next_readdata = 32'h0000_0000;
            end
        endcase
    end

    // Read data is captured in the wait cycle and held while it is taken.
    always @(posedge clk_sys_i or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            avs_readdata_o <= 32'h0000_0000;
        end
        else if (avs_read_i && !ack)
        begin
            avs_readdata_o <= next_readdata;
        end
    end
endmodule
`default_nettype wire

//--- bench/spg_board.sv
// Board model that resolves the level seen on every port pin.
`timescale 1ns/1ns
`default_nettype none
module spg_board (
    input wire logic [3:0] p4_out_i,
    input wire logic [3:0] p4_oe_i,
    input wire logic [3:0] p5_out_i,
    input wire logic [3:0] p5_oe_i,
    input wire logic [3:0] p5_pu_i,
    input wire logic [7:0] p6_out_i,
    input wire logic [7:0] p6_oe_i,
    input wire logic [3:0] ext4_i,
    input wire logic [3:0] ext5_i,
    input wire logic [7:0] ext6_i,
    output logic [3:0] p4_lvl_o,
    output logic [3:0] p5_lvl_o,
    output logic [7:0] p6_lvl_o
);
    // A driven pin shows the device level, otherwise the board source.
    assign p4_lvl_o = (p4_oe_i & p4_out_i) | (~p4_oe_i & ext4_i);
    // The board source is weak, so a connected pull-up lifts the pin.
    assign p5_lvl_o = (p5_oe_i & p5_out_i) | (~p5_oe_i & (p5_pu_i | ext5_i));
    assign p6_lvl_o = (p6_oe_i & p6_out_i) | (~p6_oe_i & ext6_i);
endmodule
`default_nettype wire

//--- bench/spg_gpio_properties.sv
// Concurrent checks on the shared pin GPIO ports.
`timescale 1ns/1ns
`default_nettype none
`include "spg_defs.vh"
module spg_gpio_properties (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic [5:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic standby_stop_i,
    input wire logic standby_watch_i,
    input wire logic [3:0] port5_pin_o,
    input wire logic [3:0] port5_pin_oe_o,
    input wire logic [3:0] port5_pullup_en_o,
    input wire logic [7:0] port6_pin_oe_o,
    input wire logic ctimer0_out_b_i,
    input wire logic ctimer0_out_b_oe_i,
    input wire logic reload_timer_in_o
);
    logic hiz_bit;
    wire logic hiz_act;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    // The standby bit is mirrored from bus writes, so no internal view.
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
            hiz_bit <= 1'b0;
        else if (avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0]
                 && avs_address_i[5:2] == `SPG_OFS_STBY)
            hiz_bit <= avs_writedata_i[`SPG_FLD_HIZ];
    end
    assign hiz_act = hiz_bit & (standby_stop_i | standby_watch_i);
    sequence s_one_wait;
        avs_waitrequest_o ##1 !avs_waitrequest_o;
    endsequence
    bus_wait_a: assert property ($rose(avs_read_i | avs_write_i) |-> s_one_wait)
        else $error("bus wait state wrong");
    bus_idle_a: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
        else $error("wait without request");
    reset_float_a: assert property ($rose(nrst_i) |-> port6_pin_oe_o == 8'h00 && port5_pin_oe_o == 4'h0)
        else $error("pin driven in reset");
    narrow_zero_a: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i[5:2] < 4'h5 |-> avs_readdata_o[31:4] == 28'h000_0000)
        else $error("narrow upper bits set");
    wide_zero_a: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i[5:2] inside {4'h5, 4'h6} |-> avs_readdata_o[31:8] == 24'h00_0000)
        else $error("wide upper bits set");
    hiz_float_a: assert property (hiz_act && $past(hiz_act) |-> port5_pin_oe_o == 4'h0 && port6_pin_oe_o == 8'h00)
        else $error("pin driven in standby");
    hiz_input_a: assert property (hiz_act && $past(hiz_act, 2) |-> !reload_timer_in_o)
        else $error("input not blocked");
    periph_own_a: assert property (ctimer0_out_b_oe_i && !hiz_act |-> port5_pin_oe_o[0] && port5_pin_o[0] == ctimer0_out_b_i)
        else $error("peripheral not on pin");
    pullup_low_a: assert property ((port5_pullup_en_o & port5_pin_oe_o & ~port5_pin_o) == 4'h0)
        else $error("pull-up on low pin");
endmodule
bind spg_gpio spg_gpio_properties u_spg_gpio_properties (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .standby_stop_i(standby_stop_i),
    .standby_watch_i(standby_watch_i),
    .port5_pin_o(port5_pin_o),
    .port5_pin_oe_o(port5_pin_oe_o),
    .port5_pullup_en_o(port5_pullup_en_o),
    .port6_pin_oe_o(port6_pin_oe_o),
    .ctimer0_out_b_i(ctimer0_out_b_i),
    .ctimer0_out_b_oe_i(ctimer0_out_b_oe_i),
    .reload_timer_in_o(reload_timer_in_o)
);
`default_nettype wire

//--- bench/spg_gpio_test.sv
// Register-level test of the shared pin GPIO ports.
`timescale 1ns/1ns
`default_nettype none
`include "spg_defs.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
    err_count++; \
    $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module spg_gpio_test;
    logic clk_sys_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [5:0] avs_address_i = 6'h00;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0000_0000;
    logic [3:0] avs_byteenable_i = 4'hf;
    logic read_modify_write_i = 1'b0;
    logic standby_stop_i = 1'b0;
    logic standby_watch_i = 1'b0;
    logic ctimer0_out_b_i = 1'b0;
    logic ctimer0_out_b_oe_i = 1'b0;
    logic ctimer0_out_a_i = 1'b0;
    logic ctimer0_out_a_oe_i = 1'b0;
    logic reload_timer_out_i = 1'b0;
    logic reload_timer_out_oe_i = 1'b0;
    logic [3:0] segment4_i = 4'h0;
    logic [3:0] ext4 = 4'h0;
    logic [3:0] ext5 = 4'h0;
    logic [7:0] ext6 = 8'h00;
    wire [31:0] avs_readdata_o;
    wire avs_waitrequest_o;
    wire [3:0] port4_pin_i, port4_pin_o, port4_pin_oe_o;
    wire [3:0] port5_pin_i, port5_pin_o, port5_pin_oe_o, port5_pullup_en_o;
    wire [7:0] port6_pin_i, port6_pin_o, port6_pin_oe_o;
    wire ctimer0_ext_clk_o;
    wire reload_timer_in_o;
    int err_count = 0;
    int total_checks = 0;
    always #25 clk_sys_i = ~clk_sys_i;
    spg_gpio u_spg_gpio (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o),
        .read_modify_write_i(read_modify_write_i),
        .standby_stop_i(standby_stop_i),
        .standby_watch_i(standby_watch_i),
        .port4_pin_i(port4_pin_i),
        .port4_pin_o(port4_pin_o),
        .port4_pin_oe_o(port4_pin_oe_o),
        .port5_pin_i(port5_pin_i),
        .port5_pin_o(port5_pin_o),
        .port5_pin_oe_o(port5_pin_oe_o),
        .port5_pullup_en_o(port5_pullup_en_o),
        .port6_pin_i(port6_pin_i),
        .port6_pin_o(port6_pin_o),
        .port6_pin_oe_o(port6_pin_oe_o),
        .ctimer0_out_b_i(ctimer0_out_b_i),
        .ctimer0_out_b_oe_i(ctimer0_out_b_oe_i),
        .ctimer0_out_a_i(ctimer0_out_a_i),
        .ctimer0_out_a_oe_i(ctimer0_out_a_oe_i),
        .reload_timer_out_i(reload_timer_out_i),
        .reload_timer_out_oe_i(reload_timer_out_oe_i),
        .ctimer0_ext_clk_o(ctimer0_ext_clk_o),
        .reload_timer_in_o(reload_timer_in_o),
        .segment4_i(segment4_i),
        .segment6_i(8'h00)
    );
    spg_board u_spg_board (.p4_out_i(port4_pin_o), .p4_oe_i(port4_pin_oe_o),
        .p5_out_i(port5_pin_o), .p5_oe_i(port5_pin_oe_o),
        .p5_pu_i(port5_pullup_en_o), .p6_out_i(port6_pin_o),
        .p6_oe_i(port6_pin_oe_o), .ext4_i(ext4), .ext5_i(ext5),
        .ext6_i(ext6), .p4_lvl_o(port4_pin_i), .p5_lvl_o(port5_pin_i),
        .p6_lvl_o(port6_pin_i));
    task automatic wr(input logic [3:0] r, input logic [31:0] d);
        @(posedge clk_sys_i);
        avs_address_i <= {r, 2'b00};
        avs_writedata_i <= d;
        avs_write_i <= 1'b1;
        do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
        avs_write_i <= 1'b0;
        @(negedge clk_sys_i);
    endtask
    task automatic rd(input logic [3:0] r, input logic m, input logic [31:0] e);
        @(posedge clk_sys_i);
        avs_address_i <= {r, 2'b00};
        read_modify_write_i <= m;
        avs_read_i <= 1'b1;
        do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
        `CHK(avs_readdata_o, e)
        avs_read_i <= 1'b0;
        @(negedge clk_sys_i);
    endtask
    task automatic wrap_up;
        if (err_count == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        #200_000;
        err_count++;
        wrap_up;
    end
    initial
    begin
        repeat (4) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        rd(`SPG_OFS_P4_DIR, 1'b0, 32'h0000_0000);
        rd(`SPG_OFS_P6_DIR, 1'b0, 32'h0000_0000);
        wr(`SPG_OFS_DISP, 32'h0001_0000);
        wr(`SPG_OFS_P4_DATA, 32'h0000_00a5);
        @(posedge clk_sys_i);
        ext4 <= 4'h3;
        repeat (3) @(negedge clk_sys_i);
        `CHK(port4_pin_oe_o, 4'h0)
        rd(`SPG_OFS_P4_DATA, 1'b0, 32'h0000_0003);
        rd(`SPG_OFS_P4_DATA, 1'b1, 32'h0000_0005);
        wr(`SPG_OFS_P4_DIR, 32'h0000_00ff);
        `CHK(port4_pin_o, 4'h5)
        `CHK(port4_pin_oe_o, 4'hf)
        rd(`SPG_OFS_P4_DATA, 1'b0, 32'h0000_0005);
        rd(`SPG_OFS_P4_DIR, 1'b0, 32'h0000_000f);
        wr(`SPG_OFS_P4_DIR, 32'h0000_000e);
        wr(`SPG_OFS_DISP, 32'h0001_0001);
        `CHK(port4_pin_o[0], 1'b0)
        @(posedge clk_sys_i);
        segment4_i <= 4'h1;
        @(negedge clk_sys_i);
        `CHK(port4_pin_oe_o[0], 1'b1)
        `CHK(port4_pin_o[0], 1'b1)
        wr(`SPG_OFS_P6_DIR, 32'h0000_00ff);
        wr(`SPG_OFS_P6_DATA, 32'h0000_003c);
        `CHK(port6_pin_o, 8'h3c)
        rd(`SPG_OFS_P6_DATA, 1'b0, 32'h0000_003c);
        @(posedge clk_sys_i);
        ctimer0_out_b_oe_i <= 1'b1;
        ctimer0_out_b_i <= 1'b1;
        ctimer0_out_a_oe_i <= 1'b1;
        ctimer0_out_a_i <= 1'b1;
        reload_timer_out_oe_i <= 1'b1;
        reload_timer_out_i <= 1'b1;
        ext5 <= 4'h2;
        repeat (3) @(negedge clk_sys_i);
        `CHK(port5_pin_oe_o, 4'hd)
        `CHK(reload_timer_in_o, 1'b1)
        `CHK(ctimer0_ext_clk_o, 1'b1)
        rd(`SPG_OFS_P5_DATA, 1'b0, 32'h0000_000f);
        rd(`SPG_OFS_P5_DATA, 1'b1, 32'h0000_0000);
        @(posedge clk_sys_i);
        ctimer0_out_b_oe_i <= 1'b0;
        ctimer0_out_a_oe_i <= 1'b0;
        reload_timer_out_oe_i <= 1'b0;
        wr(`SPG_OFS_P5_PULL, 32'h0000_000f);
        `CHK(port5_pullup_en_o, 4'hf)
        wr(`SPG_OFS_P5_DIR, 32'h0000_000f);
        `CHK(port5_pullup_en_o, 4'h0)
        wr(`SPG_OFS_P5_DATA, 32'h0000_000a);
        `CHK(port5_pullup_en_o, 4'ha)
        @(posedge clk_sys_i);
        standby_stop_i <= 1'b1;
        ext5 <= 4'hf;
        @(negedge clk_sys_i);
        `CHK(port6_pin_oe_o, 8'hff)
        `CHK(port6_pin_o, 8'h3c)
        wr(`SPG_OFS_STBY, 32'h0000_0001);
        repeat (3) @(negedge clk_sys_i);
        `CHK(port6_pin_oe_o, 8'h00)
        `CHK(port5_pin_oe_o, 4'h0)
        `CHK(reload_timer_in_o, 1'b0)
        `CHK(ctimer0_ext_clk_o, 1'b0)
        rd(`SPG_OFS_P6_DATA, 1'b1, 32'h0000_003c);
        @(posedge clk_sys_i);
        standby_stop_i <= 1'b0;
        standby_watch_i <= 1'b1;
        repeat (3) @(negedge clk_sys_i);
        `CHK(port4_pin_oe_o, 4'h0)
        wr(4'hc, 32'hffff_ffff);
        rd(4'hc, 1'b0, 32'h0000_0000);
        wrap_up;
    end
endmodule
`default_nettype wire
